/* dual_timer_counter_unit.v */
`include "timer_counter_map.vh"

module dual_timer_counter_unit (
    input wire clk_sys,
    input wire sys_rst,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire timer0CountPinIn,
    output reg timer0CountPinOut,
    output reg timer0CountPinOe,
    input wire timer1CountPinIn,
    output reg timer1CountPinOut,
    output reg timer1CountPinOe,
    input wire timer0GatePin,
    input wire timer1GatePin,
    input wire timer0IntAck,
    input wire timer1IntAck,
    output reg timer0OverflowFlag,
    output reg timer1OverflowFlag,
    output reg timer1OverflowStrobe
);

    // ***************************************************
    // Shared step function for both timers
    // ***************************************************

    // Returns {overflow, high byte, low byte} after one count
    function [16:0] stepCount;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        reg [13:0] sum13;
        reg [16:0] sum16;
        reg [8:0] sum8;
        begin
            sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            sum16 = {1'b0, hi, lo} + 17'h00001;
            sum8 = {1'b0, lo} + 9'h001;
            case (mode)
                // Upper three low bits hold, unused
                `MODE_13BIT: stepCount = {sum13[13], sum13[12:5], lo[7:5],
                    sum13[4:0]}; // RQ1
                `MODE_16BIT: stepCount = sum16; // RQ8
                // Wrap reloads low from high
                `MODE_RELOAD: stepCount = {sum8[8], hi,
                    (sum8[8] ? hi : sum8[7:0])}; // RQ9
                // Split: low byte alone, high left to caller
                default: stepCount = {sum8[8], hi, sum8[7:0]}; // RQ11
            endcase
        end
    endfunction

    // ***************************************************
    // Machine cycle tick
    // ***************************************************

    reg [2:0] mcCount_reg; // Clock counter within a machine cycle
    reg mcTick_reg; // One pulse per machine cycle

    // Six clocks per machine cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mcCount_reg <= 3'h0;
            mcTick_reg <= 1'b0;
        end else begin
            if (mcCount_reg == `MC_LAST) begin
                mcCount_reg <= 3'h0;
                mcTick_reg <= 1'b1; // RQ20
            end else begin
                mcCount_reg <= mcCount_reg + 3'h1;
                mcTick_reg <= 1'b0;
            end
        end
    end

    // ***************************************************
    // Pin synchronisers
    // ***************************************************

    wire count0Level; // Filtered count pin 0
    wire count1Level; // Filtered count pin 1
    wire gate0Level; // Filtered gate pin 0
    wire gate1Level; // Filtered gate pin 1

    pin_sync syncCount0 (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinIn(timer0CountPinIn), .level_reg(count0Level));

    pin_sync syncCount1 (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinIn(timer1CountPinIn), .level_reg(count1Level));

    pin_sync syncGate0 (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinIn(timer0GatePin), .level_reg(gate0Level));

    pin_sync syncGate1 (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinIn(timer1GatePin), .level_reg(gate1Level));

    // ***************************************************
    // Falling edge detection on count pins
    // ***************************************************

    reg sample0_reg; // Last machine-cycle sample, pin 0
    reg sample1_reg; // Last machine-cycle sample, pin 1
    wire fall0; // High then low seen, pin 0
    wire fall1; // High then low seen, pin 1

    // Sample once per machine cycle; slow but glitch tolerant
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sample0_reg <= 1'b0;
            sample1_reg <= 1'b0;
        end else if (mcTick_reg) begin
            sample0_reg <= count0Level; // RQ18
            sample1_reg <= count1Level; // RQ18
        end
    end

    assign fall0 = mcTick_reg & sample0_reg & ~count0Level; // RQ18
    assign fall1 = mcTick_reg & sample1_reg & ~count1Level; // RQ18

    // ***************************************************
    // Software registers
    // ***************************************************

    reg run0_reg; // Timer 0 run bit
    reg run1_reg; // Timer 1 run bit
    reg [3:0] extIntBits_reg; // Edge/type bits, plain storage
    reg [7:0] modeReg_reg; // Gate, select, mode fields
    reg [1:0] toggleEn_reg; // Toggle output enables
    reg [7:0] low0_reg; // Timer 0 low byte
    reg [7:0] high0_reg; // Timer 0 high byte
    reg [7:0] low1_reg; // Timer 1 low byte
    reg [7:0] high1_reg; // Timer 1 high byte

    wire busReq; // New request, not yet answered
    wire wrStrobe; // Write with low byte lane
    wire [7:0] wrByte; // Written data
    wire wrCtl; // Write to control
    wire wrMode; // Write to mode
    wire wrTgl; // Write to toggle enables
    wire wrLow0; // Write to timer 0 low
    wire wrHigh0; // Write to timer 0 high
    wire wrLow1; // Write to timer 1 low
    wire wrHigh1; // Write to timer 1 high

    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrStrobe = busReq & wb_we_i & wb_sel_i[0];
    assign wrByte = wb_dat_i[7:0];
    assign wrCtl = wrStrobe & (wb_adr_i == `OFS_CONTROL);
    assign wrMode = wrStrobe & (wb_adr_i == `OFS_MODE);
    assign wrTgl = wrStrobe & (wb_adr_i == `OFS_TOGGLE);
    assign wrLow0 = wrStrobe & (wb_adr_i == `OFS_T0_LOW);
    assign wrHigh0 = wrStrobe & (wb_adr_i == `OFS_T0_HIGH);
    assign wrLow1 = wrStrobe & (wb_adr_i == `OFS_T1_LOW);
    assign wrHigh1 = wrStrobe & (wb_adr_i == `OFS_T1_HIGH);

    // Control bits held apart from the count; start never clears it
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
            extIntBits_reg <= 4'h0;
            modeReg_reg <= `RST_BYTE;
            toggleEn_reg <= 2'h0;
        end else begin
            if (wrCtl) begin
                run1_reg <= wrByte[`CTL_T1_RUN]; // RQ7 RQ4
                run0_reg <= wrByte[`CTL_T0_RUN]; // RQ7 RQ4
                extIntBits_reg <= wrByte[3:0];
            end
            if (wrMode) begin
                modeReg_reg <= wrByte; // RQ16
            end
            if (wrTgl) begin
                toggleEn_reg <= wrByte[1:0];
            end
        end
    end

    // ***************************************************
    // Count enables
    // ***************************************************

    wire [1:0] mode0; // Timer 0 mode
    wire [1:0] mode1; // Timer 1 mode
    wire split0; // Timer 0 in split mode
    wire src0; // Timer 0 count source pulse
    wire src1; // Timer 1 count source pulse
    wire inc0; // Timer 0 (or split low) counts
    wire inc1; // Timer 1 counts
    wire incHigh0; // Split high byte counts

    assign mode0 = {modeReg_reg[`MOD_T0_MHI], modeReg_reg[`MOD_T0_MLO]};
    assign mode1 = {modeReg_reg[`MOD_T1_MHI], modeReg_reg[`MOD_T1_MLO]};
    assign split0 = (mode0 == `MODE_SPLIT);
    // Counter select: pin edges or machine cycles
    assign src0 = modeReg_reg[`MOD_T0_CSEL] ? fall0 : mcTick_reg; // RQ17
    assign src1 = modeReg_reg[`MOD_T1_CSEL] ? fall1 : mcTick_reg; // RQ17
    // Gate bit lets the gate pin hold the count off
    assign inc0 = src0 & run0_reg &
        (~modeReg_reg[`MOD_T0_GATE] | gate0Level); // RQ3 RQ5 RQ11
    // Mode 3 on timer 1 acts like a cleared run bit
    assign inc1 = src1 & run1_reg & (mode1 != `MODE_SPLIT) &
        (~modeReg_reg[`MOD_T1_GATE] | gate1Level); // RQ3 RQ5 RQ10 RQ13
    // Split high byte: machine cycles, timer 1 run bit
    assign incHigh0 = split0 & mcTick_reg & run1_reg; // RQ12

    // ***************************************************
    // Counting
    // ***************************************************

    wire [16:0] next0; // Stepped timer 0 value
    wire [16:0] next1; // Stepped timer 1 value
    wire [8:0] nextHigh0; // Stepped split high byte
    wire ovf0; // Timer 0 (or split low) overflow
    wire ovf1; // Timer 1 own overflow
    wire ovfHigh0; // Split high byte overflow

    assign next0 = stepCount(mode0, high0_reg, low0_reg);
    assign next1 = stepCount(mode1, high1_reg, low1_reg);
    assign nextHigh0 = {1'b0, high0_reg} + 9'h001;
    assign ovf0 = inc0 & next0[16]; // RQ2
    assign ovf1 = inc1 & next1[16]; // RQ2
    assign ovfHigh0 = incHigh0 & nextHigh0[8]; // RQ12

    // A software write to a byte wins over a count in that cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            low0_reg <= `RST_BYTE;
            high0_reg <= `RST_BYTE;
            low1_reg <= `RST_BYTE;
            high1_reg <= `RST_BYTE;
        end else begin
            if (wrLow0) begin
                low0_reg <= wrByte;
            end else if (inc0) begin
                low0_reg <= next0[7:0]; // RQ1 RQ8 RQ9 RQ11
            end
            if (wrHigh0) begin
                high0_reg <= wrByte;
            end else if (split0) begin
                if (incHigh0) begin
                    high0_reg <= nextHigh0[7:0]; // RQ12
                end
            end else if (inc0) begin
                high0_reg <= next0[15:8]; // RQ1 RQ8 RQ9
            end
            if (wrLow1) begin
                low1_reg <= wrByte;
            end else if (inc1) begin
                low1_reg <= next1[7:0]; // RQ1 RQ8 RQ9
            end
            if (wrHigh1) begin
                high1_reg <= wrByte;
            end else if (inc1) begin
                high1_reg <= next1[15:8]; // RQ1 RQ8 RQ9
            end
        end
    end

    // ***************************************************
    // Overflow flags and baud strobe
    // ***************************************************

    wire set0; // Hardware set, flag 0
    wire set1; // Hardware set, flag 1

    assign set0 = ovf0; // RQ2 RQ11
    // While split, only the high byte of timer 0 raises flag 1
    assign set1 = split0 ? ovfHigh0 : ovf1; // RQ12 RQ13

    // Hardware set wins over a same-cycle clear
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            timer0OverflowFlag <= 1'b0;
            timer1OverflowFlag <= 1'b0;
            timer1OverflowStrobe <= 1'b0;
        end else begin
            if (set0) begin
                timer0OverflowFlag <= 1'b1; // RQ6
            end else if (wrCtl) begin
                timer0OverflowFlag <= wrByte[`CTL_T0_FLAG]; // RQ6
            end else if (timer0IntAck) begin
                timer0OverflowFlag <= 1'b0; // RQ6
            end
            if (set1) begin
                timer1OverflowFlag <= 1'b1; // RQ6
            end else if (wrCtl) begin
                timer1OverflowFlag <= wrByte[`CTL_T1_FLAG]; // RQ6
            end else if (timer1IntAck) begin
                timer1OverflowFlag <= 1'b0; // RQ6
            end
            // Baud pulse follows timer 1 itself, in every mode except timer 1's own mode 3, where it stops
            timer1OverflowStrobe <= ovf1; // RQ19 RQ13
        end
    end

    // ***************************************************
    // Toggle outputs on shared count pins
    // ***************************************************

    // Enabling drives one first; each overflow then inverts
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            timer0CountPinOut <= 1'b1;
            timer0CountPinOe <= 1'b0;
            timer1CountPinOut <= 1'b1;
            timer1CountPinOe <= 1'b0;
        end else begin
            timer0CountPinOe <= toggleEn_reg[`TGL_T0_EN];
            timer1CountPinOe <= toggleEn_reg[`TGL_T1_EN];
            if (~toggleEn_reg[`TGL_T0_EN] | ~timer0CountPinOe) begin
                timer0CountPinOut <= 1'b1; // RQ15
            end else if (ovf0) begin
                timer0CountPinOut <= ~timer0CountPinOut; // RQ14
            end
            if (~toggleEn_reg[`TGL_T1_EN] | ~timer1CountPinOe) begin
                timer1CountPinOut <= 1'b1; // RQ15
            end else if (ovf1) begin
                timer1CountPinOut <= ~timer1CountPinOut; // RQ14
            end
        end
    end

    // ***************************************************
    // Wishbone slave
    // ***************************************************

    reg [7:0] readByte; // Selected register value

    // Read mux; unmapped addresses read zero
    always @* begin
        case (wb_adr_i)
            `OFS_CONTROL: readByte = {timer1OverflowFlag, run1_reg,
                timer0OverflowFlag, run0_reg, extIntBits_reg};
            `OFS_MODE: readByte = modeReg_reg;
            `OFS_T0_LOW: readByte = low0_reg;
            `OFS_T0_HIGH: readByte = high0_reg;
            `OFS_T1_LOW: readByte = low1_reg;
            `OFS_T1_HIGH: readByte = high1_reg;
            `OFS_TOGGLE: readByte = {6'h00, toggleEn_reg};
            default: readByte = 8'h00;
        endcase
    end

    // One-cycle answer; ack drops the cycle after it rose
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            if (busReq) begin
                wb_dat_o <= {24'h000000, readByte};
            end
        end
    end

endmodule

/* timer_counter_map.vh */
// Functional notes
// RQ1 - Mode 0 counts 13 bits, high byte plus low five
// RQ2 - Wrap from all ones sets overflow flag
// RQ3 - Count only when run and gate allows
// RQ4 - Starting a timer never clears the count
// RQ5 - Gate bits at mode bits seven and three
// RQ6 - Flags set by overflow, cleared by service or write
// RQ7 - Run bits six and four switch timers
// RQ8 - Mode 1 counts full sixteen bits
// RQ9 - Mode 2 reloads low byte from high byte
// RQ10 - Timer 1 in mode 3 simply stops
// RQ11 - Split low byte uses timer 0 controls
// RQ12 - Split high byte uses timer 1 run, flag
// RQ13 - Timer 1 runs flagless while timer 0 split
// RQ14 - Overflow inverts shared pin when toggle enabled
// RQ15 - Pin reads one until first overflow
// RQ16 - Two-bit mode field selects four modes
// RQ17 - Counter select picks machine cycles or pin
// RQ18 - Pin sampled per machine cycle, falling edge
// RQ19 - Timer 1 overflow strobe for baud logic
// RQ20 - Machine cycle tick every six clocks
`ifndef TIMER_COUNTER_MAP_VH
`define TIMER_COUNTER_MAP_VH

// ***************************************************
// Register byte addresses
// ***************************************************
`define OFS_CONTROL 8'h88
`define OFS_MODE 8'h8C
`define OFS_T0_LOW 8'h90
`define OFS_T1_LOW 8'h94
`define OFS_T0_HIGH 8'h98
`define OFS_T1_HIGH 8'h9C
`define OFS_TOGGLE 8'hA0

// ***************************************************
// Control register fields
// ***************************************************
`define CTL_T1_FLAG 7
`define CTL_T1_RUN 6
`define CTL_T0_FLAG 5
`define CTL_T0_RUN 4

// ***************************************************
// Mode register fields
// ***************************************************
`define MOD_T1_GATE 7
`define MOD_T1_CSEL 6
`define MOD_T1_MHI 5
`define MOD_T1_MLO 4
`define MOD_T0_GATE 3
`define MOD_T0_CSEL 2
`define MOD_T0_MHI 1
`define MOD_T0_MLO 0

// ***************************************************
// Toggle enable register fields
// ***************************************************
`define TGL_T0_EN 0
`define TGL_T1_EN 1

// ***************************************************
// Mode codes, reset values, timing
// ***************************************************
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`define RST_BYTE 8'h00
`define MC_LAST 3'h5

`endif

/* pin_sync.v */
// ***************************************************
// Three-stage pin synchroniser with agreement filter
// ***************************************************
module pin_sync (
    input wire clk_sys,
    input wire sys_rst,
    input wire pinIn,
    output reg level_reg
);

    reg stage1_reg; // Metastability catcher, read by stage2 only
    reg stage2_reg; // Second stage
    reg stage3_reg; // Third stage

    // Level follows only once stages two and three agree
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level_reg <= stage3_reg;
            end
        end
    end

endmodule

/* timer_unit_monitor.sv */
// ***************************************************
// Port-level checker for the dual timer unit
// ***************************************************
module timer_unit_monitor (
    input wire clk_sys,
    input wire sys_rst,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire timer0CountPinOut,
    input wire timer0CountPinOe,
    input wire timer1CountPinOut,
    input wire timer1CountPinOe,
    input wire timer0IntAck,
    input wire timer0OverflowFlag,
    input wire timer1OverflowStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    // Control write taken at this edge
    wire ctlWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_sel_i[0] && (wb_adr_i == 8'h88);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_STROBE_ONE: assert property (
        timer1OverflowStrobe |=> !timer1OverflowStrobe)
        else $error("overflow strobe too long");
    AST_FLAG_CLR: assert property ($fell(timer0OverflowFlag)
        |-> $past(timer0IntAck) || $past(ctlWrite))
        else $error("flag cleared without cause");
    AST_FLAG_HOLD: assert property (
        timer0OverflowFlag && !timer0IntAck && !ctlWrite
        |=> timer0OverflowFlag) else $error("flag dropped");
    AST_PIN_IDLE: assert property (
        !timer0CountPinOe |-> timer0CountPinOut)
        else $error("toggle output not high while idle");
    AST_PIN_FIRST: assert property (
        $rose(timer1CountPinOe) |-> timer1CountPinOut)
        else $error("toggle output low in first cycle");
endmodule

bind dual_timer_counter_unit timer_unit_monitor u_timer_unit_monitor (
    .clk_sys, .sys_rst, .wb_adr_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .timer0CountPinOut,
    .timer0CountPinOe, .timer1CountPinOut, .timer1CountPinOe,
    .timer0IntAck, .timer0OverflowFlag, .timer1OverflowStrobe
);

/* count_pin_model.sv */
// ***************************************************
// External count source sharing the toggle pin
// ***************************************************
module count_pin_model (
    input wire clk_sys,
    input wire pulseReq,
    input wire designOut,
    input wire designOe,
    output wire pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulse phase; each level held twelve clocks, two machine cycles
    logic [4:0] phase_reg = 5'h00;
    always @(posedge clk_sys) begin
        if (phase_reg != 5'h00) begin
            phase_reg <= phase_reg - 5'h01;
        end else if (pulseReq) begin
            phase_reg <= 5'h18;
        end
    end
    // Pull-up level when neither side pulls low
    assign pinLevel = designOe ? designOut : !(phase_reg > 5'h0C);
endmodule

/* tb_dual_timer_counter_unit.sv */
module tb_dual_timer_counter_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0;
    logic [3:0] wbSel = 4'h0;
    logic wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
    logic gate0 = 1'b0, gate1 = 1'b0, ack0 = 1'b0, ack1 = 1'b0;
    logic pulse0 = 1'b0, pulse1 = 1'b0;
    wire [31:0] wbDatR;
    wire wbAck, t0Level, t0Out, t0Oe, t1Level, t1Out, timer1_toggle_enable;
    wire flag0, flag1, strobe;
    // Signals the wait task can poll by index
    wire [3:0] watch = {t0Out, strobe, flag1, flag0};
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] q;

    always #10 clk_sys = ~clk_sys;

    dual_timer_counter_unit u_dual_timer_counter_unit (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_we_i(wbWe),
        .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_ack_o(wbAck), .timer0CountPinIn(t0Level),
        .timer0CountPinOut(t0Out), .timer0CountPinOe(t0Oe),
        .timer1CountPinIn(t1Level), .timer1CountPinOut(t1Out),
        .timer1CountPinOe(timer1_toggle_enable), .timer0GatePin(gate0),
        .timer1GatePin(gate1), .timer0IntAck(ack0), .timer1IntAck(ack1),
        .timer0OverflowFlag(flag0), .timer1OverflowFlag(flag1),
        .timer1OverflowStrobe(strobe));
    count_pin_model u_count_pin_model0 (.clk_sys(clk_sys),
        .pulseReq(pulse0), .designOut(t0Out), .designOe(t0Oe),
        .pinLevel(t0Level));
    count_pin_model u_count_pin_model1 (.clk_sys(clk_sys),
        .pulseReq(pulse1), .designOut(t1Out), .designOe(timer1_toggle_enable),
        .pinLevel(t1Level));

    // ***************************************************
    // Bus access, compare and wait helpers
    // ***************************************************
    // One classic cycle; ack and read data taken at the same edge
    task automatic bus(input logic [7:0] a, input logic we,
        input logic [7:0] d);
        int n;
        n = 0;
        wbAdr <= a;
        wbWe <= we;
        wbDatW <= {24'h0, d};
        wbSel <= 4'h1;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("wrong value at %0t: no bus answer", $time);
        end
        q = wbDatR[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded poll of one watched signal
    task automatic wait_sig(input int i, input logic lvl);
        int n;
        n = 0;
        while (watch[i] !== lvl && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk({7'h0, watch[i]}, {7'h0, lvl});
        @(posedge clk_sys);
    endtask
    task automatic pulse_t0;
        pulse0 <= 1'b1;
        @(posedge clk_sys);
        pulse0 <= 1'b0;
        repeat (30) @(posedge clk_sys);
    endtask
    task finish_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog; whole sequence needs well under a thousand clocks
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        finish_test;
    end

    // ***************************************************
    // Test sequence
    // ***************************************************
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(8'h88, 0, 8'h00); chk(q, 8'h00);
        bus(8'h8C, 0, 8'h00); chk(q, 8'h00);
        // Unmapped place ignores writes and reads zero
        bus(8'hB0, 1, 8'h5A); bus(8'hB0, 0, 8'h00); chk(q, 8'h00);
        // Start keeps count; carry from full low byte only
        bus(8'h98, 1, 8'h00); bus(8'h90, 1, 8'h1F);
        bus(8'h8C, 1, 8'h01); bus(8'h88, 1, 8'h10);
        repeat (20) @(posedge clk_sys);
        bus(8'h88, 1, 8'h00);
        bus(8'h90, 0, 8'h00); chk(q & 8'hF0, 8'h20);
        bus(8'h98, 0, 8'h00); chk(q, 8'h00);
        // Sixteen-bit wrap sets flag, service pulse clears it
        bus(8'h98, 1, 8'hFF); bus(8'h90, 1, 8'hFE); bus(8'h88, 1, 8'h10);
        wait_sig(0, 1'b1);
        bus(8'h88, 1, 8'h20);
        bus(8'h88, 0, 8'h00); chk(q, 8'h20);
        bus(8'h98, 0, 8'h00); chk(q, 8'h00);
        ack0 <= 1'b1;
        @(posedge clk_sys);
        ack0 <= 1'b0;
        @(posedge clk_sys);
        chk({7'h0, flag0}, 8'h00);
        // Thirteen-bit count wraps from low five bits
        bus(8'h98, 1, 8'hFF); bus(8'h90, 1, 8'h1E);
        bus(8'h8C, 1, 8'h00); bus(8'h88, 1, 8'h10);
        wait_sig(0, 1'b1);
        bus(8'h88, 1, 8'h00);
        bus(8'h98, 0, 8'h00); chk(q, 8'h00);
        // Auto-reload on timer 1 with overflow strobe
        bus(8'h9C, 1, 8'hF0); bus(8'h94, 1, 8'hFE);
        bus(8'h8C, 1, 8'h20); bus(8'h88, 1, 8'h40);
        wait_sig(2, 1'b1);
        wait_sig(1, 1'b1);
        bus(8'h88, 1, 8'h80);
        bus(8'h9C, 0, 8'h00); chk(q, 8'hF0);
        bus(8'h94, 0, 8'h00); chk(q & 8'hF0, 8'hF0);
        ack1 <= 1'b1;
        @(posedge clk_sys);
        ack1 <= 1'b0;
        @(posedge clk_sys);
        chk({7'h0, flag1}, 8'h00);
        // Gate pin low blocks counting, high lets it through
        bus(8'h88, 1, 8'h00); bus(8'h90, 1, 8'h00);
        bus(8'h8C, 1, 8'h09); bus(8'h88, 1, 8'h10);
        repeat (60) @(posedge clk_sys);
        bus(8'h90, 0, 8'h00); chk(q, 8'h00);
        gate0 <= 1'b1;
        repeat (60) @(posedge clk_sys);
        bus(8'h90, 0, 8'h00); chk({7'h0, q != 8'h00}, 8'h01);
        bus(8'h88, 1, 8'h00);
        // Split mode: high byte 0 on run 1, timer 1 halted
        bus(8'h94, 1, 8'h33); bus(8'h98, 1, 8'hFE); bus(8'h90, 1, 8'h77);
        bus(8'h8C, 1, 8'h33); bus(8'h88, 1, 8'h40);
        wait_sig(1, 1'b1);
        bus(8'h88, 1, 8'h00);
        bus(8'h90, 0, 8'h00); chk(q, 8'h77);
        bus(8'h94, 0, 8'h00); chk(q, 8'h33);
        // Timer 1 still strobes while split, but leaves flag 1 alone
        bus(8'h98, 1, 8'h00); bus(8'h94, 1, 8'hFE); bus(8'h8C, 1, 8'h23);
        bus(8'h88, 1, 8'h40);
        wait_sig(2, 1'b1);
        chk({7'h0, flag1}, 8'h00);
        bus(8'h88, 1, 8'h00);
        // Counter mode counts pin falling edges only
        bus(8'h90, 1, 8'h00); bus(8'h8C, 1, 8'h05); bus(8'h88, 1, 8'h10);
        repeat (3) pulse_t0;
        bus(8'h88, 1, 8'h00);
        bus(8'h90, 0, 8'h00); chk(q, 8'h03);
        // Toggle output: high until first overflow, then inverts
        bus(8'h98, 1, 8'hFF); bus(8'h90, 1, 8'hFF); bus(8'h8C, 1, 8'h02);
        bus(8'hA0, 1, 8'h03);
        chk({6'h0, t0Oe, t0Out}, 8'h03);
        chk({6'h0, timer1_toggle_enable, t1Out}, 8'h03);
        bus(8'h88, 1, 8'h10);
        wait_sig(3, 1'b0);
        wait_sig(3, 1'b1);
        bus(8'h88, 1, 8'h00);
        bus(8'hA0, 1, 8'h00);
        finish_test;
    end
endmodule
